// File: core/scau_cmp.sv
// Purpose: signed relation evaluator
// Assumes: operands are two's complement
// Notes: combinational
`include "scau_params.svh"
module scau_cmp (
    // operands
    input wire logic signed [`SCAU_WORD_W-1:0] a,
    input wire logic signed [`SCAU_WORD_W-1:0] b,
    input wire scau_pkg::scau_rel_t rel,
    // result
    output logic holds
);
    import scau_pkg::*;
    always_comb begin
        unique case (rel)
            SCAU_REL_EQ: holds = (a == b);
            SCAU_REL_NE: holds = (a != b);
            SCAU_REL_GT: holds = (a > b);
            SCAU_REL_LE: holds = (a <= b);
            SCAU_REL_LT: holds = (a < b);
            SCAU_REL_GE: holds = (a >= b);
            default: holds = 1'b0;
        endcase
    end
endmodule // scau_cmp

// File: core/scau_core.sv
// What this block does
// - comparison drives normally-open contact
// - six relations: eq ne gt le lt ge
// - load/parallel every scan, series gated
// - seven steps for unaligned partial-digit operand
// - addition wraps past largest positive
// - subtraction wraps past most negative
// - add in place or three-operand
// - subtract in place or three-operand
// - signed two's complement, top bit sign
// - no carry or borrow flag
// - signed 32-bit product from 16-bit sources
// - bit destination keeps four low bits per digit
// - quotient low, remainder high; bit gets quotient
// - quotient and remainder both signed
// - zero divisor raises error, no quotient
// - second accumulator or index dest errors on multiply and divide
// - comparisons are signed
//
// Purpose: signed 16-bit compare and arithmetic datapath
// Assumes: sequencer holds req stable while req_valid is high
// Notes: all outputs registered
`include "scau_params.svh"
module scau_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // request from sequencer
    input wire logic req_valid,
    input wire scau_pkg::scau_req_t req,
    output logic req_ready,
    // answer to device memory
    output scau_pkg::scau_rsp_t rsp
);
    import scau_pkg::*;
    localparam int W = `SCAU_WORD_W;
    localparam int P = `SCAU_PROD_W;

    // ========================================
    // state
    typedef enum logic [1:0] {
        SCAU_ST_IDLE = 2'b00,
        SCAU_ST_DIV = 2'b01,
        SCAU_ST_DONE = 2'b11
    } scau_st_t;
    typedef struct packed {
        scau_st_t st;
        logic ready;
        logic to_bit;
        logic [`SCAU_DIG_W-1:0] digits;
        scau_rsp_t rsp;
    } scau_core_st_t;
    scau_core_st_t s_r, s_nxt;

    // ========================================
    // helpers
    function automatic logic [P-1:0] digit_mask(
        input logic [`SCAU_DIG_W-1:0] dig);
        logic [P-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < dig) begin
                m[i*4 +: 4] = 4'hF;
            end
        end
        digit_mask = m;
    endfunction

    function automatic logic [3:0] step_count(input scau_req_t r);
        if (r.bit_src && r.digits != `SCAU_DIG_FULL && r.start_low != '0) begin
            step_count = `SCAU_STEPS_ODD;
        end else begin
            step_count = `SCAU_STEPS_NORMAL;
        end
    endfunction

    // ========================================
    // datapath
    logic holds;
    scau_cmp u_cmp (
        .a(req.first_operand),
        .b(req.second_operand),
        .rel(req.rel),
        .holds(holds)
    );

    logic div_start;
    logic div_done;
    logic signed [W-1:0] quot;
    logic signed [W-1:0] rem;
    scau_div u_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .start(div_start),
        .dividend(req.first_operand),
        .divisor(req.second_operand),
        .done(div_done),
        .quotient(quot),
        .remainder(rem)
    );

    logic take;
    logic bad_dst;
    logic signed [W-1:0] sum2;
    logic signed [W-1:0] sum3;
    logic signed [W-1:0] dif2;
    logic signed [W-1:0] dif3;
    logic signed [P-1:0] prod;
    assign take = req_valid && s_r.ready && s_r.st == SCAU_ST_IDLE;
    assign bad_dst = req.dst == SCAU_DST_ACC2 || req.dst == SCAU_DST_INDEX;
    // wrap by truncation, no carry kept
    assign sum2 = W'(req.dest_value + req.first_operand);
    assign sum3 = W'(req.first_operand + req.second_operand);
    assign dif2 = W'(req.dest_value - req.first_operand);
    assign dif3 = W'(req.first_operand - req.second_operand);
    // widen both sources first so the product is never cut at 16 bits
    assign prod = P'(req.first_operand) * P'(req.second_operand);
    assign div_start = take && req.op == SCAU_OP_DIV && !bad_dst
        && req.second_operand != '0;

    // ========================================
    // control
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp.contact_valid = 1'b0;
        s_nxt.rsp.result_valid = 1'b0;
        unique case (s_r.st)
            SCAU_ST_IDLE: begin
                s_nxt.ready = 1'b1;
                if (take) begin
                    s_nxt.rsp.operation_error_flag = 1'b0;
                    s_nxt.rsp.steps = step_count(req);
                    s_nxt.rsp.result_wide = 1'b0;
                    unique case (req.op)
                        SCAU_OP_CMP: begin
                            s_nxt.rsp.contact_valid = 1'b1;
                            if (req.con == SCAU_CON_SERIES) begin
                                // series: open unless predecessor closed and relation holds
                                s_nxt.rsp.contact =
                                    req.prev_contact && holds;
                            end else begin
                                s_nxt.rsp.contact = holds;
                            end
                        end
                        SCAU_OP_ADD2: begin
                            s_nxt.rsp.result = P'(unsigned'(sum2));
                            s_nxt.rsp.result_valid = 1'b1;
                        end
                        SCAU_OP_ADD3: begin
                            s_nxt.rsp.result = P'(unsigned'(sum3));
                            s_nxt.rsp.result_valid = 1'b1;
                        end
                        SCAU_OP_SUB2: begin
                            s_nxt.rsp.result = P'(unsigned'(dif2));
                            s_nxt.rsp.result_valid = 1'b1;
                        end
                        SCAU_OP_SUB3: begin
                            s_nxt.rsp.result = P'(unsigned'(dif3));
                            s_nxt.rsp.result_valid = 1'b1;
                        end
                        SCAU_OP_MUL: begin
                            if (bad_dst) begin
                                s_nxt.rsp.operation_error_flag = 1'b1;
                            end else if (req.dst == SCAU_DST_BIT) begin
                                s_nxt.rsp.result =
                                    prod & digit_mask(req.digits);
                                s_nxt.rsp.result_valid = 1'b1;
                            end else begin
                                s_nxt.rsp.result = prod;
                                s_nxt.rsp.result_wide = 1'b1;
                                s_nxt.rsp.result_valid = 1'b1;
                            end
                        end
                        SCAU_OP_DIV: begin
                            if (bad_dst) begin
                                s_nxt.rsp.operation_error_flag = 1'b1;
                            end else if (req.second_operand == '0) begin
                                s_nxt.rsp.operation_error_flag = 1'b1;
                            end else begin
                                s_nxt.st = SCAU_ST_DIV;
                                s_nxt.ready = 1'b0;
                                s_nxt.to_bit = req.dst == SCAU_DST_BIT;
                                s_nxt.digits = req.digits;
                            end
                        end
                        default: begin
                            s_nxt.rsp.operation_error_flag = 1'b1;
                        end
                    endcase
                end
            end
            SCAU_ST_DIV: begin
                if (div_done) begin
                    s_nxt.st = SCAU_ST_DONE;
                    s_nxt.rsp.result_valid = 1'b1;
                    if (s_r.to_bit) begin
                        s_nxt.rsp.result = P'(unsigned'(quot))
                            & digit_mask(s_r.digits);
                    end else begin
                        s_nxt.rsp.result = {rem, quot};
                        s_nxt.rsp.result_wide = 1'b1;
                    end
                end
            end
            SCAU_ST_DONE: begin
                s_nxt.st = SCAU_ST_IDLE;
                s_nxt.ready = 1'b1;
            end
            default: begin
                s_nxt.st = SCAU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req_ready = s_r.ready;
    assign rsp = s_r.rsp;
endmodule // scau_core

// File: core/scau_div.sv
// Purpose: signed restoring divider, one bit per cycle
// Assumes: divisor checked for zero by caller
// Notes: truncates toward zero
`include "scau_params.svh"
module scau_div (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // request
    input wire logic start,
    input wire logic signed [`SCAU_WORD_W-1:0] dividend,
    input wire logic signed [`SCAU_WORD_W-1:0] divisor,
    // answer
    output logic done,
    output logic signed [`SCAU_WORD_W-1:0] quotient,
    output logic signed [`SCAU_WORD_W-1:0] remainder
);
    import scau_pkg::*;
    localparam int W = `SCAU_WORD_W;
    typedef struct packed {
        logic busy;
        logic done;
        logic [4:0] cnt;
        logic [W-1:0] q;
        logic [W:0] r;
        logic [W-1:0] d;
        logic qneg;
        logic rneg;
    } scau_div_st_t;
    scau_div_st_t s_r, s_nxt;

    function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
        mag = v[W-1] ? W'(-v) : v;
    endfunction

    logic [W:0] trial;
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        trial = {s_r.r[W-1:0], s_r.q[W-1]} - {1'b0, s_r.d};
        if (start) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = 5'(W);
            s_nxt.q = mag(dividend);
            s_nxt.r = '0;
            s_nxt.d = mag(divisor);
            s_nxt.qneg = dividend[W-1] ^ divisor[W-1];
            s_nxt.rneg = dividend[W-1];
        end else if (s_r.busy) begin
            if (trial[W]) begin
                s_nxt.r = {s_r.r[W-1:0], s_r.q[W-1]};
                s_nxt.q = {s_r.q[W-2:0], 1'b0};
            end else begin
                s_nxt.r = trial;
                s_nxt.q = {s_r.q[W-2:0], 1'b1};
            end
            s_nxt.cnt = s_r.cnt - 5'h01;
            if (s_r.cnt == 5'h01) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign done = s_r.done;
    assign quotient = s_r.qneg ? W'(-s_r.q) : s_r.q;
    assign remainder = s_r.rneg ? W'(-s_r.r[W-1:0]) : s_r.r[W-1:0];
endmodule // scau_div

// File: core/scau_params.svh
// Purpose: constants for the signed compare/arith unit
// Assumes: 16-bit signed operands
// Notes: included by the package and modules
`ifndef SCAU_PARAMS_SVH
`define SCAU_PARAMS_SVH
`define SCAU_WORD_W 16
`define SCAU_PROD_W 32
`define SCAU_DIG_W 3
`define SCAU_DIG_FULL 3'h4
`define SCAU_STEPS_NORMAL 4'h5
`define SCAU_STEPS_ODD 4'h7
`define SCAU_BYTE_ALIGN_W 3
`define SCAU_DIV_LAT 5'h11
`endif

// File: core/scau_pkg.sv
// Purpose: types for the signed compare/arith unit
// Assumes: scau_params.svh holds the numbers
// Notes: none
`include "scau_params.svh"
package scau_pkg;
    typedef enum logic [3:0] {
        SCAU_OP_CMP = 4'h0,
        SCAU_OP_ADD2 = 4'h1,
        SCAU_OP_ADD3 = 4'h2,
        SCAU_OP_SUB2 = 4'h3,
        SCAU_OP_SUB3 = 4'h4,
        SCAU_OP_MUL = 4'h5,
        SCAU_OP_DIV = 4'h6
    } scau_op_t;
    typedef enum logic [2:0] {
        SCAU_REL_EQ = 3'h0,
        SCAU_REL_NE = 3'h1,
        SCAU_REL_GT = 3'h2,
        SCAU_REL_LE = 3'h3,
        SCAU_REL_LT = 3'h4,
        SCAU_REL_GE = 3'h5
    } scau_rel_t;
    typedef enum logic [1:0] {
        SCAU_CON_LOAD = 2'h0,
        SCAU_CON_SERIES = 2'h1,
        SCAU_CON_PARALLEL = 2'h2
    } scau_con_t;
    typedef enum logic [1:0] {
        SCAU_DST_WORD = 2'h0,
        SCAU_DST_BIT = 2'h1,
        SCAU_DST_ACC2 = 2'h2,
        SCAU_DST_INDEX = 2'h3
    } scau_dst_t;
    typedef struct packed {
        scau_op_t op;
        scau_rel_t rel;
        scau_con_t con;
        scau_dst_t dst;
        logic [`SCAU_DIG_W-1:0] digits;
        logic bit_src;
        logic [`SCAU_BYTE_ALIGN_W-1:0] start_low;
        logic prev_contact;
        logic signed [`SCAU_WORD_W-1:0] first_operand;
        logic signed [`SCAU_WORD_W-1:0] second_operand;
        logic signed [`SCAU_WORD_W-1:0] dest_value;
    } scau_req_t;
    typedef struct packed {
        logic contact;
        logic contact_valid;
        logic [`SCAU_PROD_W-1:0] result;
        logic result_wide;
        logic result_valid;
        logic operation_error_flag;
        logic [3:0] steps;
    } scau_rsp_t;
endpackage : scau_pkg

// File: tb/scau_core_chk.sv
// Purpose: port checker for the signed compare/arith core
// Assumes: one clock, synchronous active-low reset
// Notes: bound to scau_core below
module scau_core_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // request
    input wire logic req_valid,
    input wire scau_pkg::scau_req_t req,
    input wire logic req_ready,
    // answer
    input wire scau_pkg::scau_rsp_t rsp
);
    import scau_pkg::*;
    logic take;
    logic holds;
    logic [15:0] add_w;
    logic [15:0] sub_w;
    logic signed [31:0] mul_w;
    assign take = req_valid && req_ready;
    assign add_w = req.first_operand + req.second_operand;
    assign sub_w = req.first_operand - req.second_operand;
    assign mul_w = req.first_operand * req.second_operand;
    always_comb begin
        case (req.rel)
            SCAU_REL_EQ: holds = req.first_operand == req.second_operand;
            SCAU_REL_NE: holds = req.first_operand != req.second_operand;
            SCAU_REL_GT: holds = req.first_operand > req.second_operand;
            SCAU_REL_LE: holds = req.first_operand <= req.second_operand;
            SCAU_REL_LT: holds = req.first_operand < req.second_operand;
            SCAU_REL_GE: holds = req.first_operand >= req.second_operand;
            default: holds = 1'b0;
        endcase
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ====================
    // assertions
    a_contact_rel: assert property (
        take && req.op == SCAU_OP_CMP && req.con != SCAU_CON_SERIES
        |=> rsp.contact_valid && rsp.contact == $past(holds))
        else $error("contact disagrees with relation");
    a_series_gate: assert property (
        take && req.op == SCAU_OP_CMP && req.con == SCAU_CON_SERIES
        |=> rsp.contact == ($past(holds) && $past(req.prev_contact)))
        else $error("series contact not gated");
    a_steps_odd: assert property (
        take && req.bit_src && req.digits != 3'h4 && req.start_low != 3'h0
        |=> rsp.steps == 4'h7)
        else $error("step count not seven");
    a_add_wrap: assert property (
        take && req.op == SCAU_OP_ADD3
        |=> rsp.result == {16'h0000, $past(add_w)})
        else $error("sum not wrapped");
    a_sub_wrap: assert property (
        take && req.op == SCAU_OP_SUB3
        |=> rsp.result == {16'h0000, $past(sub_w)})
        else $error("difference not wrapped");
    a_mul_word: assert property (
        take && req.op == SCAU_OP_MUL && req.dst == SCAU_DST_WORD
        |=> rsp.result == $past(mul_w))
        else $error("product wrong");
    a_div_zero: assert property (
        take && req.op == SCAU_OP_DIV && req.second_operand == 16'h0000
        |=> rsp.operation_error_flag && !rsp.result_valid)
        else $error("zero divisor not flagged");
    a_bad_dest: assert property (
        take && (req.op == SCAU_OP_MUL || req.op == SCAU_OP_DIV)
        && (req.dst == SCAU_DST_ACC2 || req.dst == SCAU_DST_INDEX)
        |=> rsp.operation_error_flag)
        else $error("illegal destination not flagged");
    a_clean_flag: assert property (
        take && req.op inside {SCAU_OP_ADD2, SCAU_OP_ADD3,
        SCAU_OP_SUB2, SCAU_OP_SUB3}
        |=> !rsp.operation_error_flag)
        else $error("flag set by clean add or subtract");
    a_div_time: assert property (
        take && req.op == SCAU_OP_DIV && req.second_operand != 16'h0000
        && req.dst == SCAU_DST_WORD
        |=> !req_ready ##17 rsp.result_valid)
        else $error("division answer late or early");
endmodule // scau_core_chk
bind scau_core scau_core_chk u_chk (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .rsp(rsp)
);

// File: tb/tb.sv
// Purpose: self-checking bench for scau_core
// Assumes: inputs driven at falling edge
// Notes: operation tables per scenario
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scau_pkg::*;
    logic sys_clk, rstn, req_valid, req_ready, rdy1;
    scau_req_t req, r;
    scau_rsp_t rsp, got;
    int bad_count, n_tests;
    always #4 sys_clk = ~sys_clk;
    scau_core dut (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp(rsp));
    // ====================
    // helpers
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask
    task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task hang;
        bad_count++;
        $display("[ERR] wait exp answer got timeout");
        finish_test();
    endtask
    function automatic logic rel_ok(scau_rel_t rl, logic signed [15:0] a,
        logic signed [15:0] b);
        case (rl)
            SCAU_REL_EQ: return a == b;
            SCAU_REL_NE: return a != b;
            SCAU_REL_GT: return a > b;
            SCAU_REL_LE: return a <= b;
            SCAU_REL_LT: return a < b;
            default: return a >= b;
        endcase
    endfunction
    // issue r once ready, keep the first answer in got
    task go;
        int k;
        k = 0;
        while (req_ready !== 1'b1) begin
            k++;
            if (k > 40) hang();
            @(negedge sys_clk);
        end
        req = r;
        req_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        // valid pulses stand only one cycle after the edge that raises them
        rdy1 = req_ready;
        for (k = 0; k < 30; k++) begin
            got = rsp;
            if ((rsp.contact_valid | rsp.result_valid
                | rsp.operation_error_flag) === 1'b1) break;
            @(negedge sys_clk);
            req_valid = 1'b0;
            @(posedge sys_clk);
            #1;
        end
        if (k == 30) hang();
        @(negedge sys_clk);
        req_valid = 1'b0;
    endtask
    // ====================
    // scenarios
    task t_cmp;
        logic [15:0] av [3] = '{16'h8001, 16'h0005, 16'h0064};
        logic [15:0] bv [3] = '{16'h0568, 16'h0005, 16'hFFFD};
        r = '0;
        r.digits = 3'h4;
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 6; j++) begin
                r.rel = scau_rel_t'(3'(j));
                r.first_operand = av[i];
                r.second_operand = bv[i];
                go();
                chk1("contact", rel_ok(r.rel, av[i], bv[i]), got.contact);
                chk32("steps", 32'h5, 32'(got.steps));
            end
        end
        r.bit_src = 1'b1;
        r.digits = 3'h2;
        r.start_low = 3'h3;
        go();
        chk32("steps", 32'h7, 32'(got.steps));
        r.digits = 3'h4;
        go();
        chk32("steps", 32'h5, 32'(got.steps));
        $display("compare done");
    endtask
    task t_series;
        scau_con_t cv [4] = '{SCAU_CON_SERIES, SCAU_CON_SERIES,
            SCAU_CON_PARALLEL, SCAU_CON_LOAD};
        logic pv [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        logic ev [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
        r = '0;
        r.digits = 3'h4;
        for (int i = 0; i < 4; i++) begin
            r.con = cv[i];
            r.prev_contact = pv[i];
            go();
            chk1("contact", ev[i], got.contact);
            chk1("cvalid", 1'b1, got.contact_valid);
        end
        $display("series done");
    endtask
    task t_addsub;
        scau_op_t ov [4] = '{SCAU_OP_ADD3, SCAU_OP_ADD2,
            SCAU_OP_SUB3, SCAU_OP_SUB2};
        logic [15:0] av [4] = '{16'h7FFF, 16'h0001, 16'h8000, 16'h0001};
        logic [15:0] bv [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001};
        logic [15:0] dv [4] = '{16'h0000, 16'h7FFF, 16'h0000, 16'h8000};
        logic [15:0] ev [4] = '{16'h8000, 16'h8000, 16'h7FFF, 16'h7FFF};
        r = '0;
        r.digits = 3'h4;
        for (int i = 0; i < 4; i++) begin
            r.op = ov[i];
            r.first_operand = av[i];
            r.second_operand = bv[i];
            r.dest_value = dv[i];
            go();
            chk32("sum", {16'h0000, ev[i]}, got.result);
            chk1("flag", 1'b0, got.operation_error_flag);
            chk1("wide", 1'b0, got.result_wide);
            chk1("ready", 1'b1, rdy1);
        end
        $display("add sub done");
    endtask
    task t_muldiv;
        logic [15:0] av [6] = '{16'h162E, 16'hFFFB, 16'hFFFB,
            16'hFFF9, 16'h0005, 16'hFFFB};
        logic [15:0] bv [6] = '{16'h04D2, 16'h0003, 16'h0003,
            16'h0002, 16'hFFFD, 16'hFFFD};
        logic signed [31:0] p;
        logic signed [15:0] q, m;
        r = '0;
        for (int i = 0; i < 6; i++) begin
            r.op = i < 3 ? SCAU_OP_MUL : SCAU_OP_DIV;
            r.dst = i == 2 || i == 5 ? SCAU_DST_BIT : SCAU_DST_WORD;
            r.digits = i == 2 ? 3'h1 : 3'h4;
            r.first_operand = av[i];
            r.second_operand = bv[i];
            p = $signed(av[i]) * $signed(bv[i]);
            q = $signed(av[i]) / $signed(bv[i]);
            m = $signed(av[i]) % $signed(bv[i]);
            if (i >= 3) p = r.dst == SCAU_DST_WORD ? {m, q} : {16'h0000, q};
            if (r.dst == SCAU_DST_BIT) p = p & ((32'h1 << (4 * r.digits)) - 1);
            go();
            chk32("result", p, got.result);
            chk1("valid", 1'b1, got.result_valid);
            chk1("wide", r.dst == SCAU_DST_WORD, got.result_wide);
            chk1("ready", i < 3, rdy1);
        end
        $display("mul div done");
    endtask
    task t_err;
        scau_op_t ov [4] = '{SCAU_OP_DIV, SCAU_OP_MUL, SCAU_OP_DIV,
            SCAU_OP_MUL};
        scau_dst_t dv [4] = '{SCAU_DST_WORD, SCAU_DST_ACC2, SCAU_DST_INDEX,
            SCAU_DST_WORD};
        logic [15:0] bv [4] = '{16'h0000, 16'h0003, 16'h0003, 16'h0003};
        r = '0;
        r.digits = 3'h4;
        r.first_operand = 16'h0009;
        for (int i = 0; i < 4; i++) begin
            r.op = ov[i];
            r.dst = dv[i];
            r.second_operand = bv[i];
            go();
            chk1("flag", i < 3, got.operation_error_flag);
            chk1("valid", i == 3, got.result_valid);
        end
        $display("error done");
    endtask
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        r = '0;
        rdy1 = 1'b0;
        bad_count = 0;
        n_tests = 0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk1("ready", 1'b0, req_ready);
        rstn = 1'b1;
        t_cmp();
        t_series();
        t_addsub();
        t_muldiv();
        t_err();
        finish_test();
    end
endmodule // tb
